// ==== verilog/wwdt_pkg.sv ====
package wwdt_pkg;

	// ==========================================================
	// Counter and prescaler
	localparam int          CNT_WIDTH   = 16;    // Watchdog counter width
	localparam int          DIV_SLOW    = 16384; // Coarse prescale factor
	localparam int          DIV_FAST    = 256;   // Fine prescale factor
	localparam int          PRE_WIDTH   = 14;    // Prescaler counter width

	// ==========================================================
	// Default interval at power-up, wake-up clock at 500 kHz
	localparam int          WU_FREQ_KHZ        = 500;
	localparam int          DEFAULT_TIMEOUT_US = 130000;
	// Prescaled ticks that fit into the default interval (rounded down)
	localparam int          DEFAULT_TICKS =
		DEFAULT_TIMEOUT_US * WU_FREQ_KHZ / 1000 / DIV_FAST;
	localparam logic [15:0] RELOAD_RST  = 16'(65536 - DEFAULT_TICKS);
	localparam logic [15:0] WINDOW_RST  = 16'h0000;

	// ==========================================================
	// Register byte offsets
	localparam logic [7:0]  CTRL_OFS    = 8'h00;
	localparam logic [7:0]  RELOAD_OFS  = 8'h04;
	localparam logic [7:0]  WINDOW_OFS  = 8'h08;
	localparam logic [7:0]  SERVICE_OFS = 8'h0C;
	localparam logic [7:0]  STATUS_OFS  = 8'h10;

	// ==========================================================
	// Field positions
	localparam int          CTRL_CLK_SEL_BIT = 0;  // 1 = wake-up oscillator
	localparam int          CTRL_DIV_SEL_BIT = 1;  // 1 = divide by 16384
	localparam int          ST_ENABLED_BIT   = 16;
	localparam int          ST_OVF_BIT       = 17; // Sticky, write 1 to clear
	localparam int          ST_EARLY_BIT     = 18; // Sticky, write 1 to clear

	// Control reset: wake-up clock, divide by 256
	localparam logic        CLK_SEL_RST = 1'b1;
	localparam logic        DIV_SEL_RST = 1'b0;

	// ==========================================================
	// Bus responses
	localparam logic [1:0]  RESP_OKAY   = 2'h0;
	localparam logic [1:0]  RESP_SLVERR = 2'h2;

	// Counter clocking choices
	typedef struct packed {
		logic div_slow; // Select coarse divider
		logic clk_wu;   // Select wake-up oscillator
	} ctrl_t;

	// Latched causes of a reset request
	typedef struct packed {
		logic early;    // Refresh inside forbidden window
		logic overflow; // Counter ran out
	} cause_t;

endpackage

// ==== verilog/wwdt_prescaler.sv ====
`timescale 1ns/1ps
`default_nettype none

module wwdt_prescaler
	import wwdt_pkg::*;
#(
	parameter int SLOW = DIV_SLOW,
	parameter int FAST = DIV_FAST
) (
	// Clock and reset
	input  wire logic aclk,
	input  wire logic aresetn,
	// Source and selection
	input  wire logic src_tick,
	input  wire logic div_slow,
	// Prescaled tick
	output logic      tick
);

	// ==========================================================
	// Division counter
	logic [PRE_WIDTH-1:0] cnt;   // Source ticks so far
	logic [PRE_WIDTH-1:0] last;  // Terminal value for the chosen factor

	assign last = div_slow ? PRE_WIDTH'(SLOW - 1) : PRE_WIDTH'(FAST - 1);

	// Count source ticks and wrap at the chosen factor
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cnt  <= '0;
			tick <= 1'b0;
		end else if (src_tick && cnt >= last) begin
			// Wrap also catches a switch to the short factor mid-count
			cnt  <= '0;
			tick <= 1'b1;
		end else begin
			cnt  <= src_tick ? cnt + 1'b1 : cnt;
			tick <= 1'b0;
		end
	end

	// ==========================================================
	// Checking helpers: source ticks between two output ticks
	logic [15:0] gap;
	logic        settled;  // One output tick seen with a fixed factor

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			gap     <= '0;
			settled <= 1'b0;
		end else if (div_slow != $past(div_slow)) begin
			gap     <= '0;
			settled <= 1'b0;
		end else if (tick) begin
			gap     <= 16'(src_tick);
			settled <= 1'b1;
		end else begin
			gap     <= gap + 16'(src_tick);
		end
	end

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	prescale_ratio_a: assert property (
		tick && settled && $stable(div_slow)
		|-> gap == (div_slow ? 16'(SLOW) : 16'(FAST)))
		else $error("prescaled tick spacing differs from divide factor");

endmodule

`default_nettype wire

// ==== verilog/window_watchdog_timer.sv ====
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - Enabled and counting after every reset
// - Disable command stops, enable command resumes
// - Unserviced overflow raises a reset request
// - Refresh inside forbidden window raises request
// - Sixteen-bit up-counter, system or wake-up clock
// - Prescaler divides by 16384 or 256
// - Valid service loads the reload value
// - Power-up default gives about 0.13 s

module window_watchdog_timer
	import wwdt_pkg::*;
#(
	parameter int WIDTH = CNT_WIDTH
) (
	// Clock and reset
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// AXI4-Lite write address
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	// AXI4-Lite write data
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	// AXI4-Lite write response
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	// AXI4-Lite read address
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	// AXI4-Lite read data
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	// Core commands
	input  wire logic        watchdog_disable_cmd,
	input  wire logic        watchdog_enable_cmd,
	// Second count source
	input  wire logic        wakeup_osc_clock,
	// Request to system reset logic
	output logic             reset_req
);

	// ==========================================================
	// Software visible state
	ctrl_t             ctrl;               // Clock and divider choice
	logic [WIDTH-1:0]  timer_reload_value; // Loaded on each accepted (not early) service
	logic [WIDTH-1:0]  window_bound;       // Earliest accepted count
	logic [WIDTH-1:0]  count;              // Watchdog counter
	logic              enabled;            // Counter runs
	cause_t            cause;              // Sticky reasons

	// ==========================================================
	// Write channel
	logic [7:0]  aw_addr;    // Held write address
	logic [31:0] w_data;     // Held write data
	logic [3:0]  w_strb;     // Held byte enables
	logic        do_write;   // Both halves held, response free
	logic        wr_hit;     // Address decodes

	assign do_write = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;

	// Known offsets
	function automatic logic known_ofs(input logic [7:0] a);
		return a == CTRL_OFS || a == RELOAD_OFS || a == WINDOW_OFS ||
			a == SERVICE_OFS || a == STATUS_OFS;
	endfunction

	// Merge byte lanes into an old word
	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] nw, input logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				r[8*i +: 8] = nw[8*i +: 8];
			end
		end
		return r;
	endfunction

	assign wr_hit = known_ofs(aw_addr);

	// Address accept, one at a time
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b1;
			aw_addr       <= '0;
		end else if (s_axi_awvalid && s_axi_awready) begin
			s_axi_awready <= 1'b0;
			aw_addr       <= s_axi_awaddr;
		end else if (s_axi_bvalid && s_axi_bready) begin
			s_axi_awready <= 1'b1;
		end
	end

	// Data accept, independent of address order
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_wready <= 1'b1;
			w_data       <= '0;
			w_strb       <= '0;
		end else if (s_axi_wvalid && s_axi_wready) begin
			s_axi_wready <= 1'b0;
			w_data       <= s_axi_wdata;
			w_strb       <= s_axi_wstrb;
		end else if (s_axi_bvalid && s_axi_bready) begin
			s_axi_wready <= 1'b1;
		end
	end

	// Response one cycle after both halves are in
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= RESP_OKAY;
		end else if (do_write) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// ==========================================================
	// Configuration registers
	logic [31:0] ctrl_word;
	logic [31:0] reload_word;
	logic [31:0] window_word;

	assign ctrl_word   = merge(32'(ctrl), w_data, w_strb);
	assign reload_word = merge(32'(timer_reload_value), w_data, w_strb);
	assign window_word = merge(32'(window_bound), w_data, w_strb);

	// Power-up defaults set the 0.13 s interval
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl.clk_wu        <= CLK_SEL_RST;
			ctrl.div_slow      <= DIV_SEL_RST;
			timer_reload_value <= WIDTH'(RELOAD_RST);
			window_bound       <= WIDTH'(WINDOW_RST);
		end else if (do_write) begin
			if (aw_addr == CTRL_OFS) begin
				ctrl.clk_wu   <= ctrl_word[CTRL_CLK_SEL_BIT];
				ctrl.div_slow <= ctrl_word[CTRL_DIV_SEL_BIT];
			end
			if (aw_addr == RELOAD_OFS) begin
				timer_reload_value <= reload_word[WIDTH-1:0];
			end
			if (aw_addr == WINDOW_OFS) begin
				window_bound <= window_word[WIDTH-1:0];
			end
		end
	end

	// ==========================================================
	// Count source and prescaler
	logic wu_prev;   // Last wake-up clock level
	logic src_tick;  // One source clock period
	logic tick;      // Prescaled count step

	// Tracks the pin through reset too, so release brings no false edge
	always_ff @(posedge aclk) begin
		wu_prev <= wakeup_osc_clock;
	end

	// Wake-up clock must stay below half the bus clock
	assign src_tick = ctrl.clk_wu ? (wakeup_osc_clock && !wu_prev) : 1'b1;

	wwdt_prescaler #(
		.SLOW (DIV_SLOW),
		.FAST (DIV_FAST)
	) u_pre (
		.aclk     (aclk),
		.aresetn  (aresetn),
		.src_tick (src_tick),
		.div_slow (ctrl.div_slow),
		.tick     (tick)
	);

	// ==========================================================
	// Service decisions
	logic service;      // Software refresh this cycle
	logic early;        // Refresh in forbidden part
	logic overflow;     // Counter runs past all ones
	logic status_w1c;   // Status write this cycle

	assign service    = do_write && aw_addr == SERVICE_OFS;
	assign early      = service && enabled && count < window_bound;
	assign overflow   = enabled && tick && &count && !service;
	assign status_w1c = do_write && aw_addr == STATUS_OFS && w_strb[2];

	// Enable state; enable wins when both arrive together
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			enabled <= 1'b1;
		end else if (watchdog_enable_cmd) begin
			enabled <= 1'b1;
		end else if (watchdog_disable_cmd) begin
			enabled <= 1'b0;
		end
	end

	// Counter: an accepted (not early) service beats a step in the same cycle
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			count <= WIDTH'(RELOAD_RST);
		end else if (service && !early) begin
			count <= timer_reload_value;
		end else if (overflow) begin
			// Reload so a missed reset does not wrap to zero silently
			count <= timer_reload_value;
		end else if (enabled && tick) begin
			count <= count + 1'b1;
		end
	end

	// Single registered request pulse
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			reset_req <= 1'b0;
		end else begin
			reset_req <= overflow || early;
		end
	end

	// Sticky causes; a new event beats a clear
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cause <= '0;
		end else begin
			cause.overflow <= overflow ||
				(cause.overflow && !(status_w1c && w_data[ST_OVF_BIT]));
			cause.early    <= early ||
				(cause.early && !(status_w1c && w_data[ST_EARLY_BIT]));
		end
	end

	// ==========================================================
	// Read channel
	logic [7:0]  ar_addr;   // Held read address
	logic        rd_pend;   // Address held, data not yet out
	logic [31:0] rd_word;   // Decoded read value

	assign rd_pend = !s_axi_arready && !s_axi_rvalid;

	// Read mux, unused bits zero
	always_comb begin
		rd_word = '0;
		unique case (ar_addr)
			CTRL_OFS: begin
				rd_word[CTRL_CLK_SEL_BIT] = ctrl.clk_wu;
				rd_word[CTRL_DIV_SEL_BIT] = ctrl.div_slow;
			end
			RELOAD_OFS: rd_word[WIDTH-1:0] = timer_reload_value;
			WINDOW_OFS: rd_word[WIDTH-1:0] = window_bound;
			STATUS_OFS: begin
				rd_word[WIDTH-1:0]      = count;
				rd_word[ST_ENABLED_BIT] = enabled;
				rd_word[ST_OVF_BIT]     = cause.overflow;
				rd_word[ST_EARLY_BIT]   = cause.early;
			end
			default: rd_word = '0;
		endcase
	end

	// Address accept
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b1;
			ar_addr       <= '0;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_arready <= 1'b0;
			ar_addr       <= s_axi_araddr;
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_arready <= 1'b1;
		end
	end

	// Data one cycle after address
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= '0;
			s_axi_rresp  <= RESP_OKAY;
		end else if (rd_pend) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata  <= rd_word;
			s_axi_rresp  <= known_ofs(ar_addr) ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	// ==========================================================
	// Checks
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	sequence good_service_s;
		service && !early;
	endsequence

	sequence run_out_s;
		enabled && tick && &count && !service;
	endsequence

	reset_enabled_a: assert property (
		!$past(aresetn) |-> enabled && count == WIDTH'(RELOAD_RST))
		else $error("watchdog not running after reset");

	disable_stops_a: assert property (
		watchdog_disable_cmd && !watchdog_enable_cmd
		##1 (!watchdog_enable_cmd && !service) [*3] |-> !enabled && $stable(count))
		else $error("counter moved while disabled");

	enable_resumes_a: assert property (
		watchdog_enable_cmd |=> enabled)
		else $error("enable command ignored");

	overflow_req_a: assert property (
		run_out_s |=> reset_req && cause.overflow && count == $past(timer_reload_value))
		else $error("overflow gave no reset request");

	early_req_a: assert property (
		service && enabled && count < window_bound
		|=> reset_req && cause.early &&
			(count == $past(count) || count == $past(count) + 1'b1))
		else $error("early refresh not rejected");

	count_step_a: assert property (
		enabled && tick && !service && !(&count) |=> count == $past(count) + 1'b1)
		else $error("counter did not step up");

	reload_a: assert property (
		good_service_s |=> count == $past(timer_reload_value) && !reset_req)
		else $error("service did not load reload value");

	default_cfg_a: assert property (
		!$past(aresetn) |-> ctrl.clk_wu && !ctrl.div_slow &&
			timer_reload_value == WIDTH'(RELOAD_RST))
		else $error("power-up interval settings wrong");

	req_pulse_a: assert property (
		reset_req |=> !reset_req)
		else $error("reset request longer than one cycle");

endmodule

`default_nettype wire

// ==== tb/wwdt_core_model.sv ====
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// Core and system reset controller stand-in
module wwdt_core_model #(
	parameter int WU_HALF = 4 // Aclk cycles per wake-up half period
) (
	// Clock and reset
	input  wire logic aclk,
	input  wire logic aresetn,
	// Bench requests for core commands
	input  wire logic want_off,
	input  wire logic want_on,
	// Toward the watchdog
	output logic      watchdog_disable_cmd,
	output logic      watchdog_enable_cmd,
	output logic      wakeup_osc_clock,
	// From the watchdog
	input  wire logic reset_req,
	output var int    req_count
);
	int ph = 0; // Oscillator phase

	// Core issues commands whenever software asks, with no pacing
	assign watchdog_disable_cmd = want_off;
	assign watchdog_enable_cmd  = want_on;

	// Oscillator runs free, even through reset, as the real one does
	initial wakeup_osc_clock = 1'b0;
	always @(posedge aclk) begin
		ph <= (ph == WU_HALF - 1) ? 0 : ph + 1;
		if (ph == WU_HALF - 1) begin
			wakeup_osc_clock <= ~wakeup_osc_clock;
		end
	end

	// Reset controller logs each request; a long pulse counts once per cycle
	initial req_count = 0;
	always @(posedge aclk) begin
		if (aresetn && reset_req === 1'b1) begin
			req_count <= req_count + 1;
		end
	end
endmodule

`default_nettype wire

// ==== tb/window_watchdog_timer_test.sv ====
`timescale 1ns/1ps
`default_nettype none

module window_watchdog_timer_test;
	import wwdt_pkg::*;

	// ==========================================================
	// Signals
	localparam int WU_HALF = 4;
	logic        aclk = 1'b0, aresetn = 1'b0;
	logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
	logic [3:0]  s_axi_wstrb = 4'h0;
	logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
	logic        s_axi_bready = 1'b1, s_axi_rready = 1'b1; // Always ready for answers
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0]  s_axi_bresp, s_axi_rresp, rs;
	logic        want_off = 1'b0, want_on = 1'b0;
	logic        watchdog_disable_cmd, watchdog_enable_cmd, wakeup_osc_clock, reset_req;
	logic [15:0] val, win;
	int          req_count, n, failures = 0, n_checks = 0;

	window_watchdog_timer dut (
		.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
		.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
		.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
		.watchdog_disable_cmd, .watchdog_enable_cmd, .wakeup_osc_clock, .reset_req
	);

	wwdt_core_model #(.WU_HALF(WU_HALF)) partner (
		.aclk, .aresetn, .want_off, .want_on, .watchdog_disable_cmd,
		.watchdog_enable_cmd, .wakeup_osc_clock, .reset_req, .req_count
	);

	// 100 MHz clock
	initial begin
		forever #5 aclk = ~aclk;
	end

	// ==========================================================
	// Expectations
	function automatic logic [15:0] default_reload();
		// 0.13 s of 500 kHz edges divided by 256, counted up to the wrap
		return 16'(32'h10000 - 130000 * 500 / 1000 / 256);
	endfunction

	function automatic logic [31:0] status_of(input logic [15:0] c, input logic en);
		return {15'h0, en, c};
	endfunction

	// ==========================================================
	// Checking and ending
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			failures++;
			$display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic print_verdict;
		$display("Checks %0d, mismatches %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	// ==========================================================
	// Bus master: address and data offered together, each held until taken
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
		logic aw_ok, w_ok;
		aw_ok = 1'b0;
		w_ok = 1'b0;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_wstrb <= s;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		while (!(aw_ok && w_ok)) begin
			@(posedge aclk);
			if (!aw_ok && s_axi_awready === 1'b1) begin
				aw_ok = 1'b1;
				s_axi_awvalid <= 1'b0;
			end
			if (!w_ok && s_axi_wready === 1'b1) begin
				w_ok = 1'b1;
				s_axi_wvalid <= 1'b0;
			end
		end
		do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
		rs = s_axi_bresp;
	endtask

	task automatic rd_reg(input logic [7:0] a);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		do @(posedge aclk); while (s_axi_arready !== 1'b1);
		s_axi_arvalid <= 1'b0;
		do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
		rd = s_axi_rdata;
		rs = s_axi_rresp;
	endtask

	// One-cycle command from the core; a quiet edge follows
	task automatic cmd(input logic off, input logic on);
		want_off <= off;
		want_on <= on;
		@(posedge aclk);
		want_off <= 1'b0;
		want_on <= 1'b0;
		@(posedge aclk);
	endtask

	// Edges until the next request pulse
	task automatic wait_req;
		n = 0;
		do begin
			@(posedge aclk);
			n++;
		end while (reset_req !== 1'b1 && n < 40000);
	endtask

	// Reload at the top, so pulse spacing is one prescaled period
	task automatic interval(input logic [31:0] ctl, input int cycles);
		wr(CTRL_OFS, ctl, 4'h1);
		wr(RELOAD_OFS, 32'h0000FFFF, 4'h3);
		wr(SERVICE_OFS, 32'h0, 4'h1);
		wait_req;
		wait_req;
		check(32'(n), 32'(cycles));
		$display("Interval test done, control %h", ctl);
	endtask

	// ==========================================================
	// Hang guard
	initial begin
		repeat (90000) @(posedge aclk);
		failures++;
		print_verdict;
	end

	// ==========================================================
	// Main sequence
	initial begin
		void'($urandom(38));
		repeat (12) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		// Power-up state: counting enabled, default interval loaded
		rd_reg(STATUS_OFS);
		check(rd, status_of(default_reload(), 1'b1));
		check(32'(rs), 32'(RESP_OKAY));
		rd_reg(RELOAD_OFS);
		check(rd, {16'h0, default_reload()});
		rd_reg(CTRL_OFS);
		check(rd, 32'h1);
		rd_reg(8'h14);
		check(rd, 32'h0);
		check(32'(rs), 32'(RESP_SLVERR));
		// Unmapped write is refused, a mapped one answers okay
		wr(8'h14, 32'hFFFFFFFF, 4'hF);
		check(32'(rs), 32'(RESP_SLVERR));
		wr(WINDOW_OFS, 32'h0, 4'h3);
		check(32'(rs), 32'(RESP_OKAY));
		$display("Reset test done");

		// Overflow spacing for every clock and divider choice except wake-up clock with divide by 16384
		interval(32'h0, 256);
		interval(32'h2, 16384);
		interval(32'h1, 512 * WU_HALF);
		wr(RELOAD_OFS, 32'h0, 4'h3);
		wr(SERVICE_OFS, 32'h0, 4'h1);
		rd_reg(STATUS_OFS);
		check(rd[17], 1'b1);
		wr(STATUS_OFS, 32'h00060000, 4'h4);
		rd_reg(STATUS_OFS);
		check(rd[18:16], 3'h1);
		$display("Overflow test done");

		// Freeze while disabled, reload on service, resume on enable
		wr(CTRL_OFS, 32'h0, 4'h1);
		for (int i = 0; i < 6; i++) begin
			val = 16'($urandom_range(32'hFFF0));
			cmd(1'b1, 1'b0);
			wr(RELOAD_OFS, {16'h0, val}, 4'h3);
			wr(SERVICE_OFS, 32'h0, 4'h1);
			rd_reg(STATUS_OFS);
			check(rd, status_of(val, 1'b0));
			repeat (300) @(posedge aclk);
			rd_reg(STATUS_OFS);
			check(rd, status_of(val, 1'b0));
			cmd(1'b1, 1'b1);
			repeat (600) @(posedge aclk);
			rd_reg(STATUS_OFS);
			check(32'(rd[15:0] - val inside {16'h2, 16'h3}), 32'h1);
		end
		$display("Enable test done");

		// Refresh one below the boundary, then exactly at it
		wr(CTRL_OFS, 32'h2, 4'h1);
		cmd(1'b1, 1'b0);
		win = 16'($urandom_range(32'hF000, 32'h0100));
		wr(WINDOW_OFS, {16'h0, win}, 4'h3);
		wr(RELOAD_OFS, {16'h0, win - 16'h1}, 4'h3);
		wr(SERVICE_OFS, 32'h0, 4'h1);
		wr(RELOAD_OFS, 32'h0, 4'h3);
		cmd(1'b0, 1'b1);
		n = req_count;
		wr(SERVICE_OFS, 32'h0, 4'h1);
		repeat (3) @(posedge aclk);
		check(32'(req_count - n), 32'h1);
		rd_reg(STATUS_OFS);
		check(rd[18:0], {3'h5, win - 16'h1});
		cmd(1'b1, 1'b0);
		wr(RELOAD_OFS, {16'h0, win}, 4'h3);
		wr(SERVICE_OFS, 32'h0, 4'h1);
		// Different reload, so an accepted service is seen to load it
		wr(RELOAD_OFS, {16'h0, ~win}, 4'h3);
		cmd(1'b0, 1'b1);
		n = req_count;
		wr(SERVICE_OFS, 32'h0, 4'h1);
		repeat (3) @(posedge aclk);
		check(32'(req_count - n), 32'h0);
		rd_reg(STATUS_OFS);
		check({16'h0, rd[15:0]}, {16'h0, ~win});
		$display("Window test done");

		// Reset in mid-run after a disable re-enables the watchdog
		cmd(1'b1, 1'b0);
		aresetn <= 1'b0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		rd_reg(STATUS_OFS);
		check(rd, status_of(default_reload(), 1'b1));
		$display("Second reset test done");
		print_verdict;
	end
endmodule

`default_nettype wire
